// *** verilog/strobe_pkg.sv ***
// Purpose: Shared constants and types for the strobe shutter timing block
// Assumes: 25 MHz system clock, APB register access
// Notes:   Delay settings are kept in their panel units (us or 10 ns steps)
package strobe_pkg;
    // Clock and time base
    localparam int CLK_PERIOD_NS = 40;
    localparam int NS10_PER_CLK  = CLK_PERIOD_NS / 10;
    localparam int US_NS10       = 100;
    localparam int US_CYCLES     = 1000 / CLK_PERIOD_NS;
    localparam int FRAME_NS      = 33_333_333;
    localparam int FRAME_CYCLES  = FRAME_NS / CLK_PERIOD_NS;
    localparam int LASER_WIN_CYC = FRAME_CYCLES * 30;

    // Shutter gate and laser pulse widths, rounded up to whole cycles
    localparam int GATE_FAST_NS  = 70;
    localparam int GATE_MED_NS   = 500;
    localparam int GATE_SLOW_NS  = 5000;
    localparam int GATE_FAST_CYC = (GATE_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GATE_MED_CYC  = (GATE_MED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GATE_SLOW_CYC = (GATE_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LASER_PULSE_NS  = 1000;
    localparam int LASER_PULSE_CYC = (LASER_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Protection limits and the fixed source B delay
    localparam int DUTY_DIV        = 200;
    localparam int LASER_RATE_MAX  = 64;
    localparam logic [23:0] B_DELAY_NS10 = 24'h000032;

    // Setting ranges
    localparam logic [13:0] SET_MIN = 14'h0001;
    localparam logic [13:0] SET_MAX = 14'h270f;
    localparam logic [13:0] INTERVAL_MIN = 14'h0002;

    // Register offsets
    localparam logic [7:0] CTRL_OFF     = 8'h00;
    localparam logic [7:0] HOLDOFF_OFF  = 8'h04;
    localparam logic [7:0] SYNC_OFF     = 8'h08;
    localparam logic [7:0] INTERVAL_OFF = 8'h0c;
    localparam logic [7:0] STATUS_OFF   = 8'h10;
    localparam logic [7:0] IRQ_EN_OFF   = 8'h14;
    localparam logic [7:0] IRQ_CLR_OFF  = 8'h18;
    localparam logic [7:0] STATE_OFF    = 8'h1c;

    // Reset values
    localparam logic [10:0] CTRL_RST     = 11'h004;
    localparam logic [13:0] HOLDOFF_RST  = 14'h0001;
    localparam logic [13:0] SYNC_RST     = 14'h0001;
    localparam logic [13:0] INTERVAL_RST = 14'h0002;

    // Status bit positions
    localparam int ST_EXPOSE    = 0;
    localparam int ST_REJECT    = 1;
    localparam int ST_GATE_INH  = 2;
    localparam int ST_LASER_INH = 3;
    localparam int ST_W         = 4;

    // Source select codes
    localparam logic [1:0] SRC_A    = 2'h1;
    localparam logic [1:0] SRC_B    = 2'h2;
    localparam logic [1:0] SRC_BOTH = 2'h3;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_HOLD = 2'b01,
        SEQ_RUN  = 2'b10
    } seq_e;

    // Control register layout, bit 0 at the bottom
    typedef struct packed {
        logic [2:0] rate_select;
        logic       laser_arm;
        logic       shutter_on;
        logic [1:0] gate_speed;
        logic [1:0] source_select;
        logic       falling_edge_select;
        logic       outside_source_mode;
    } cfg_s;
endpackage : strobe_pkg

// *** verilog/edge_trigger_in.sv ***
// Purpose: Synchronise the outside trigger pin and pick the active edge
// Assumes: Pin is asynchronous to clk
// Notes:   Output pulse lags the pin by three clocks
module edge_trigger_in (
    input  wire logic clk,        // System clock
    input  wire logic srst,       // Sync reset
    input  wire logic pin,        // Raw trigger pin
    input  wire logic fall_sel,   // Falling edge when high
    output logic      edge_pulse  // One-cycle edge pulse
);
    logic sync1_q, sync2_q, last_q, pulse_q;
    logic pulse_d;

    always_comb begin
        pulse_d = fall_sel ? (last_q & ~sync2_q) : (~last_q & sync2_q);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            last_q  <= 1'b0;
            pulse_q <= 1'b0;
        end else begin
            sync1_q <= pin;
            sync2_q <= sync1_q;
            last_q  <= sync2_q;
            pulse_q <= pulse_d;
        end
    end

    assign edge_pulse = pulse_q;

    property p_edge_dir;
        @(posedge clk) disable iff (srst)
        pulse_q |-> ($past(sync2_q) != $past(last_q)) && ($past(sync2_q) == ~$past(fall_sel));
    endproperty
    a_edge_dir: assert property (p_edge_dir) else $error("trigger edge of wrong direction");
endmodule : edge_trigger_in

// *** verilog/rate_guard.sv ***
// Purpose: Count activity in fixed windows and inhibit when over a limit
// Assumes: active is a level or pulse on clk
// Notes:   Inhibit also spans the window after an over-limit one
module rate_guard #(
    parameter int WINDOW = 1000,  // Window length in cycles
    parameter int LIMIT  = 5      // Counts allowed per window
) (
    input  wire logic clk,        // System clock
    input  wire logic srst,       // Sync reset
    input  wire logic active,     // Counted activity
    output logic      inhibit     // Protection trip
);
    localparam int WW = $clog2(WINDOW + 1);
    localparam int HW = $clog2(LIMIT + 2);

    logic [WW-1:0] win_q, win_d;
    logic [HW-1:0] hit_q, hit_d;
    logic          prev_q, prev_d, inh_q, inh_d, over;

    always_comb begin
        over   = (hit_q > HW'(LIMIT));
        win_d  = win_q + WW'(1);
        hit_d  = (active && !over) ? hit_q + HW'(1) : hit_q;
        prev_d = prev_q;
        if (win_q == WW'(WINDOW - 1)) begin
            win_d  = '0;
            hit_d  = '0;
            prev_d = over;
        end
        inh_d = over | prev_q;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            win_q  <= '0;
            hit_q  <= '0;
            prev_q <= 1'b0;
            inh_q  <= 1'b0;
        end else begin
            win_q  <= win_d;
            hit_q  <= hit_d;
            prev_q <= prev_d;
            inh_q  <= inh_d;
        end
    end

    assign inhibit = inh_q;
endmodule : rate_guard

// *** verilog/strobe_timer.sv ***
// Purpose: Trigger, delay and shutter gate sequencer with APB registers
// Assumes: 25 MHz clk, lasers and shutter driver take active-high pulses
// Notes:   Delays count in 10 ns units, stepping 4 units per clock
//
// Operation
// - Outside trigger uses selected rising/falling edge
// - Fire holdoff 1 us to 9.999 ms
// - Drop triggers whose holdoff overruns the frame
// - Fire A only, B only, or both
// - Shutter gate follows source A by sync
// - Sync delay 10 ns to 99.99 us steps
// - Source B adds fixed delay to sync
// - B fires interval after A, 2us-9.999ms
// - Fast gate about 70 ns, others longer
// - Block shutter gate above 0.5 percent duty
// - Block laser triggers at abnormal rates
// - Gate pulses only while shutter is on
// - Armed laser fires per picture or trigger
// - Self-timed rates 30,15,10,6,5,3,1 per second
// - Test outside triggers, ignore failing ones
module strobe_timer
    import strobe_pkg::*;
#(
    parameter int FRAME_CYC = strobe_pkg::FRAME_CYCLES,  // Video frame length
    parameter int LASER_WIN = strobe_pkg::LASER_WIN_CYC  // Laser rate window
) (
    input  wire logic        clk,        // 25 MHz clock
    input  wire logic        srst,       // Sync reset
    input  wire logic        psel,       // APB select
    input  wire logic        penable,    // APB enable
    input  wire logic        pwrite,     // APB write
    input  wire logic [7:0]  paddr,      // APB byte address
    input  wire logic [31:0] pwdata,     // APB write data
    output logic      [31:0] prdata,     // APB read data
    output logic             pready,     // APB ready
    output logic             pslverr,    // APB error
    input  wire logic        trig_pin,   // Outside trigger pin
    output logic             laser_a,    // Source A fire pulse
    output logic             laser_b,    // Source B fire pulse
    output logic             gate,       // Intensifier shutter gate
    output logic             irq         // Level interrupt
);
    import strobe_pkg::*;

    cfg_s          cfg;
    logic [10:0]   ctrl_q, ctrl_d;
    logic [13:0]   holdoff_q, holdoff_d, sync_q, sync_d, intv_q, intv_d;
    logic [ST_W-1:0] stat_q, stat_d, en_q, en_d, ev;
    logic [31:0]   prdata_q, prdata_d, rdata;
    logic          pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
    logic          wr, addr_ok;

    seq_e          state_q, state_d;
    logic [23:0]   t_q, t_d, frame_q, frame_d;
    logic [4:0]    pic_q, pic_d;
    logic          taken_q, taken_d;
    logic          fa_q, fa_d, ga_q, ga_d, fb_q, fb_d, gb_q, gb_d;
    logic [7:0]    gcnt_q, gcnt_d;
    logic [5:0]    la_q, la_d, lb_q, lb_d;
    logic          gate_q, gate_d, laser_a_q, laser_a_d, laser_b_q, laser_b_d;

    logic          trig, frame_tick, fits, use_a, use_b, run_done, start_int;
    logic          fa_go, ga_go, fb_go, gb_go, accept, reject;
    logic          gate_inh, laser_inh;
    logic [23:0]   hold_tgt, hold_cyc, sync_tgt, tb_tgt, gb_tgt;
    logic [7:0]    gate_w;
    logic [4:0]    pic_div;

    assign cfg = cfg_s'(ctrl_q);

    edge_trigger_in u_edge (
        .clk        (clk),
        .srst       (srst),
        .pin        (trig_pin),
        .fall_sel   (cfg.falling_edge_select),
        .edge_pulse (trig)
    );

    // Duty is measured on the requested gate so a stuck gate keeps the trip
    rate_guard #(.WINDOW(FRAME_CYC), .LIMIT(FRAME_CYC / DUTY_DIV)) u_duty (
        .clk     (clk),
        .srst    (srst),
        .active  (gcnt_q != 8'h00),
        .inhibit (gate_inh)
    );

    rate_guard #(.WINDOW(LASER_WIN), .LIMIT(LASER_RATE_MAX)) u_lrate (
        .clk     (clk),
        .srst    (srst),
        .active  (fa_go | fb_go),
        .inhibit (laser_inh)
    );

    function automatic logic [13:0] clamp(input logic [31:0] v, input logic [13:0] lo);
        logic [13:0] r;
        r = SET_MAX;
        if (v < 32'(lo)) begin
            r = lo;
        end else if (v <= 32'(SET_MAX)) begin
            r = v[13:0];
        end
        return r;
    endfunction : clamp

    // Register file and APB slave: no wait state on any access
    always_comb begin
        addr_ok = (paddr[1:0] == 2'h0) && (paddr <= STATE_OFF);
        wr      = psel & penable & pready_q & pwrite & addr_ok;
        case (paddr)
            CTRL_OFF:     rdata = {21'h0, ctrl_q};
            HOLDOFF_OFF:  rdata = {18'h0, holdoff_q};
            SYNC_OFF:     rdata = {18'h0, sync_q};
            INTERVAL_OFF: rdata = {18'h0, intv_q};
            STATUS_OFF:   rdata = {28'h0, stat_q};
            IRQ_EN_OFF:   rdata = {28'h0, en_q};
            STATE_OFF:    rdata = {28'h0, laser_inh, gate_inh, state_q};
            default:      rdata = 32'h0;
        endcase
        pready_d  = psel & ~penable;
        pslverr_d = psel & ~penable & ~addr_ok;
        prdata_d  = (psel & ~penable & ~pwrite) ? rdata : prdata_q;
        ctrl_d    = (wr && paddr == CTRL_OFF) ? pwdata[10:0] : ctrl_q;
        holdoff_d = (wr && paddr == HOLDOFF_OFF) ? clamp(pwdata, SET_MIN) : holdoff_q;
        sync_d    = (wr && paddr == SYNC_OFF) ? clamp(pwdata, SET_MIN) : sync_q;
        intv_d    = (wr && paddr == INTERVAL_OFF) ? clamp(pwdata, INTERVAL_MIN) : intv_q;
        en_d      = (wr && paddr == IRQ_EN_OFF) ? pwdata[ST_W-1:0] : en_q;
        stat_d    = stat_q;
        if (wr && paddr == IRQ_CLR_OFF) begin
            stat_d = stat_q & ~pwdata[ST_W-1:0];
        end
        stat_d = stat_d | ev;  // Set wins over a same-cycle clear
        irq_d  = |(stat_d & en_d);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_q    <= CTRL_RST;
            holdoff_q <= HOLDOFF_RST;
            sync_q    <= SYNC_RST;
            intv_q    <= INTERVAL_RST;
            stat_q    <= '0;
            en_q      <= '0;
            prdata_q  <= 32'h0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q     <= 1'b0;
        end else begin
            ctrl_q    <= ctrl_d;
            holdoff_q <= holdoff_d;
            sync_q    <= sync_d;
            intv_q    <= intv_d;
            stat_q    <= stat_d;
            en_q      <= en_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            irq_q     <= irq_d;
        end
    end

    // Frame timing and exposure sequencer
    always_comb begin
        case (cfg.rate_select)
            3'h0:    pic_div = 5'd1;
            3'h1:    pic_div = 5'd2;
            3'h2:    pic_div = 5'd3;
            3'h3:    pic_div = 5'd5;
            3'h4:    pic_div = 5'd6;
            3'h5:    pic_div = 5'd10;
            default: pic_div = 5'd30;
        endcase
        case (cfg.gate_speed)
            2'h0:    gate_w = 8'(GATE_FAST_CYC);
            2'h1:    gate_w = 8'(GATE_MED_CYC);
            default: gate_w = 8'(GATE_SLOW_CYC);
        endcase
        use_a    = cfg.source_select[0];
        use_b    = cfg.source_select[1];
        hold_tgt = 24'(holdoff_q) * 24'(US_NS10);
        hold_cyc = 24'(holdoff_q) * 24'(US_CYCLES);
        sync_tgt = 24'(sync_q);
        tb_tgt   = (cfg.source_select == SRC_BOTH) ? 24'(intv_q) * 24'(US_NS10) : 24'h0;
        gb_tgt   = tb_tgt + sync_tgt + B_DELAY_NS10;
        frame_tick = (frame_q == 24'(FRAME_CYC - 1));
        frame_d    = frame_tick ? 24'h0 : frame_q + 24'h1;
        pic_d      = pic_q;
        if (frame_tick) begin
            pic_d = (pic_q + 5'd1 >= pic_div) ? 5'd0 : pic_q + 5'd1;
        end
        // Holdoff must expire inside the current frame
        fits   = ({4'h0, frame_q} + {4'h0, hold_cyc}) < 28'(FRAME_CYC);
        accept = cfg.outside_source_mode & trig & (state_q == SEQ_IDLE) & ~taken_q & fits;
        reject = cfg.outside_source_mode & trig & ~accept;
        start_int = ~cfg.outside_source_mode & frame_tick & (pic_q == 5'd0)
                    & (state_q == SEQ_IDLE);
        taken_d = frame_tick ? 1'b0 : (taken_q | accept);

        fa_go = (state_q == SEQ_RUN) & use_a & ~fa_q;
        ga_go = (state_q == SEQ_RUN) & use_a & ~ga_q & (t_q >= sync_tgt);
        fb_go = (state_q == SEQ_RUN) & use_b & ~fb_q & (t_q >= tb_tgt);
        gb_go = (state_q == SEQ_RUN) & use_b & ~gb_q & (t_q >= gb_tgt);
        fa_d  = fa_q | fa_go;
        ga_d  = ga_q | ga_go;
        fb_d  = fb_q | fb_go;
        gb_d  = gb_q | gb_go;
        run_done = (~use_a | ga_q) & (~use_b | gb_q) & (gcnt_q == 8'h00);

        gcnt_d = (ga_go | gb_go) ? gate_w :
                 (gcnt_q != 8'h00) ? gcnt_q - 8'h01 : 8'h00;
        la_d   = fa_go ? 6'(LASER_PULSE_CYC) : (la_q != 6'h0) ? la_q - 6'h1 : 6'h0;
        lb_d   = fb_go ? 6'(LASER_PULSE_CYC) : (lb_q != 6'h0) ? lb_q - 6'h1 : 6'h0;
        gate_d    = (gcnt_d != 8'h00) & cfg.shutter_on & ~gate_inh;
        laser_a_d = (la_d != 6'h0) & cfg.laser_arm & ~laser_inh;
        laser_b_d = (lb_d != 6'h0) & cfg.laser_arm & ~laser_inh;

        state_d = state_q;
        t_d     = t_q + 24'(NS10_PER_CLK);
        case (state_q)
            SEQ_IDLE: begin
                t_d = 24'h0;
                if (accept) begin
                    state_d = SEQ_HOLD;
                end else if (start_int) begin
                    state_d = SEQ_RUN;
                end
            end
            SEQ_HOLD: begin
                if (t_q >= hold_tgt) begin
                    state_d = SEQ_RUN;
                    t_d     = 24'h0;
                end
            end
            SEQ_RUN: begin
                if (run_done) begin
                    state_d = SEQ_IDLE;
                end
            end
            default: begin
                state_d = SEQ_IDLE;
            end
        endcase
        if (state_d != SEQ_RUN) begin
            fa_d = 1'b0;
            ga_d = 1'b0;
            fb_d = 1'b0;
            gb_d = 1'b0;
        end
        ev = '0;
        ev[ST_EXPOSE]    = (state_q == SEQ_RUN) & run_done;
        ev[ST_REJECT]    = reject;
        ev[ST_GATE_INH]  = gate_inh;
        ev[ST_LASER_INH] = laser_inh;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q   <= SEQ_IDLE;
            t_q       <= 24'h0;
            frame_q   <= 24'h0;
            pic_q     <= 5'd0;
            taken_q   <= 1'b0;
            fa_q      <= 1'b0;
            ga_q      <= 1'b0;
            fb_q      <= 1'b0;
            gb_q      <= 1'b0;
            gcnt_q    <= 8'h00;
            la_q      <= 6'h0;
            lb_q      <= 6'h0;
            gate_q    <= 1'b0;
            laser_a_q <= 1'b0;
            laser_b_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            t_q       <= t_d;
            frame_q   <= frame_d;
            pic_q     <= pic_d;
            taken_q   <= taken_d;
            fa_q      <= fa_d;
            ga_q      <= ga_d;
            fb_q      <= fb_d;
            gb_q      <= gb_d;
            gcnt_q    <= gcnt_d;
            la_q      <= la_d;
            lb_q      <= lb_d;
            gate_q    <= gate_d;
            laser_a_q <= laser_a_d;
            laser_b_q <= laser_b_d;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign irq     = irq_q;
    assign gate    = gate_q;
    assign laser_a = laser_a_q;
    assign laser_b = laser_b_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_holdoff;
        ($past(state_q) == SEQ_HOLD && state_q == SEQ_RUN) |-> $past(t_q) >= $past(hold_tgt);
    endproperty
    a_holdoff: assert property (p_holdoff) else $error("holdoff cut short");

    property p_nofit;
        (trig && cfg.outside_source_mode && !fits) |=> state_q != SEQ_HOLD || $past(state_q) == SEQ_HOLD;
    endproperty
    a_nofit: assert property (p_nofit) else $error("unfit trigger accepted");

    property p_src_a_only;
        (cfg.source_select == SRC_A) |-> !fb_go && !gb_go;
    endproperty
    a_src_a_only: assert property (p_src_a_only) else $error("source B fired in A mode");

    property p_gate_after_sync;
        ga_go |-> (t_q >= 24'(sync_q)) && fa_q;
    endproperty
    a_gate_after_sync: assert property (p_gate_after_sync) else $error("gate before sync");

    property p_b_gate;
        gb_go |-> t_q >= tb_tgt + 24'(sync_q) + B_DELAY_NS10;
    endproperty
    a_b_gate: assert property (p_b_gate) else $error("B gate too early");

    property p_fast_gate;
        (ga_go && cfg.gate_speed == 2'h0) |=> (gcnt_q != 8'h00) [*2] ##1 gcnt_q == 8'h00;
    endproperty
    a_fast_gate: assert property (p_fast_gate) else $error("fast gate width wrong");

    property p_duty_block;
        gate_inh |=> !gate_q;
    endproperty
    a_duty_block: assert property (p_duty_block) else $error("gate during duty trip");

    property p_rate_block;
        laser_inh |=> !laser_a_q && !laser_b_q;
    endproperty
    a_rate_block: assert property (p_rate_block) else $error("laser during rate trip");

    property p_shutter_off;
        !cfg.shutter_on |=> !gate_q;
    endproperty
    a_shutter_off: assert property (p_shutter_off) else $error("gate with shutter off");

    property p_unarmed;
        !cfg.laser_arm |=> !laser_a_q && !laser_b_q;
    endproperty
    a_unarmed: assert property (p_unarmed) else $error("laser fired unarmed");

    property p_int_start;
        ($past(state_q) == SEQ_IDLE && state_q == SEQ_RUN) |-> $past(frame_tick);
    endproperty
    a_int_start: assert property (p_int_start) else $error("self-timed start off frame");

    property p_reject_flag;
        reject |=> stat_q[ST_REJECT];
    endproperty
    a_reject_flag: assert property (p_reject_flag) else $error("reject not flagged");

    property p_tick;
        (state_q == SEQ_RUN && $past(state_q) == SEQ_RUN) |-> t_q == $past(t_q) + 24'd4;
    endproperty
    a_tick: assert property (p_tick) else $error("time base step wrong");

    c_double: cover property (gb_go && cfg.source_select == SRC_BOTH);
    c_outside: cover property (accept ##[1:1000] state_q == SEQ_RUN);
    c_reject: cover property (reject);
    c_gate: cover property ($rose(gate_q));
endmodule : strobe_timer

// *** test/strobe_far_side.sv ***
// Purpose: Far-side model of the light sources and shutter driver
// Assumes: Active-high fire and gate pulses, sampled on clk
// Notes:   Listens only, so a missing pulse shows up as a count gap
module strobe_far_side (
    input  wire logic clk,     // Clock
    input  wire logic laser_a, // A fire
    input  wire logic laser_b, // B fire
    input  wire logic gate,    // Gate
    input  var  int   cyc,     // Cycle count
    output var  int   n_a = 0, // A pulses
    output var  int   n_b = 0, // B pulses
    output var  int   n_g = 0, // Gates
    output var  int   t_a,     // A rise
    output var  int   t_b,     // B rise
    output var  int   t_g,     // Gate rise
    output var  int   w_g      // Gate width
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] p  = 3'h0;
    int         wc = 0;
    always @(posedge clk) begin
        p <= {laser_a, laser_b, gate};
        if (laser_a && !p[2]) n_a <= n_a + 1;
        if (laser_a && !p[2]) t_a <= cyc;
        if (laser_b && !p[1]) n_b <= n_b + 1;
        if (laser_b && !p[1]) t_b <= cyc;
        if (gate && !p[0]) n_g <= n_g + 1;
        if (gate && !p[0]) t_g <= cyc;
        // Width in whole high cycles
        wc <= gate ? wc + 1 : 0;
        if (!gate && p[0]) w_g <= wc;
    end
endmodule : strobe_far_side

// *** test/strobe_timer_test.sv ***
// Purpose: Self-checking bench for strobe_timer
// Assumes: Short frame and laser windows keep the run brief
// Notes:   Frame phase is tracked from the bench cycle count
module strobe_timer_test;
    timeunit 1ns;
    timeprecision 1ns;
    import strobe_pkg::*;
    localparam int          FR = 6000;
    localparam logic [7:0]  OFS [7] = '{CTRL_OFF, HOLDOFF_OFF, SYNC_OFF, INTERVAL_OFF,
                                        STATUS_OFF, IRQ_EN_OFF, STATE_OFF};
    localparam logic [13:0] RST [7] = '{14'(CTRL_RST), HOLDOFF_RST, SYNC_RST,
                                        INTERVAL_RST, 14'h0, 14'h0, 14'h0};
    logic        clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, trig_pin = 0;
    logic        pready, pslverr, laser_a, laser_b, gate, irq, er;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h8;
    int          cyc = 0, err_count = 0, num_checks = 0, n_a, n_b, n_g, t_a, t_b, t_g, w_g;
    strobe_timer #(.FRAME_CYC(FR), .LASER_WIN(FR)) i_strobe_timer (
        .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trig_pin(trig_pin), .laser_a(laser_a), .laser_b(laser_b),
        .gate(gate), .irq(irq));
    strobe_far_side i_strobe_far_side (.clk(clk), .laser_a(laser_a), .laser_b(laser_b),
        .gate(gate), .cyc(cyc), .n_a(n_a), .n_b(n_b), .n_g(n_g), .t_a(t_a), .t_b(t_b),
        .t_g(t_g), .w_g(w_g));
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    function automatic logic [31:0] ctl(int r, logic a, sh, logic [1:0] sp, s, logic f, o);
        cfg_s c;
        c = '{3'(r), a, sh, sp, s, f, o};
        return 32'(c);
    endfunction : ctl
    function automatic logic near(int d, int e);
        return d >= e - 2 && d <= e + 3;
    endfunction : near
    task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
        num_checks++;
        if (got !== ex) begin
            err_count++;
            $display("wrong value %s expected %0h seen %0h", nm, ex, got);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge clk);
        if (k == 20) begin
            chk("pready", 1, 0);
            give_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic align(int p);
        int k;
        for (k = 0; k < FR && (cyc - 13) % FR != p; k++) @(posedge clk);
        if (k == FR) begin
            chk("frame align", 1, 0);
            give_verdict();
        end
    endtask : align
    task automatic shot(int ho, logic [1:0] s, logic f, logic [1:0] sp, logic sh, arm);
        int a0, b0, g0, tp, sy, iv, ok, e, r;
        seed = xs(seed);
        if (ho == 0) ho = 1 + int'(seed % 20);
        sy = 1 + int'(seed[15:8]);
        iv = 3 + int'(seed[19:16]);
        ok = int'(ho * 25 < FR - 20);
        // Park at the active level while the old polarity is still selected
        trig_pin <= ~f;
        apb(1, HOLDOFF_OFF, 32'(ho));
        apb(1, SYNC_OFF, 32'(sy));
        apb(1, INTERVAL_OFF, 32'(iv));
        apb(1, CTRL_OFF, ctl(0, arm, sh, sp, s, f, 1));
        // Idle level first: an edge of the wrong polarity must not start a shot
        trig_pin <= f;
        align(20);
        {a0, b0, g0, tp} = {n_a, n_b, n_g, cyc};
        trig_pin <= ~f;
        repeat (1200) @(posedge clk);
        chk("laser a count", 32'(ok & arm & s[0]), 32'(n_a - a0));
        chk("laser b count", 32'(ok & arm & s[1]), 32'(n_b - b0));
        chk("gate count", 32'(ok * sh * (int'(s[0]) + s[1])), 32'(n_g - g0));
        e = (sy + (s[1] ? int'(B_DELAY_NS10) : 0) + 3) / 4;
        r = s[1] ? t_b : t_a;
        if (ok && arm) begin
            chk("holdoff", 1, 32'(near((s[0] ? t_a : t_b) - tp, ho * 25 + 6)));
            if (s == SRC_BOTH) chk("a to b", 1, 32'(near(t_b - t_a, iv * 25)));
            if (sh) chk("sync", 1, 32'(near(t_g - r, e)));
        end
        if (ok && sh && sp < 2) chk("gate width", sp ? GATE_MED_CYC : GATE_FAST_CYC, 32'(w_g));
        if (ok && sh && sp > 1) chk("gate cut", 1, 32'(w_g < GATE_SLOW_CYC));
        apb(0, STATUS_OFF, 0);
        if (sh) chk("status", 32'({sp > 1, ok == 0, ok != 0}), 32'(rd[2:0]));
        if (sh) chk("irq", 32'(ok), 32'(irq));
        apb(1, IRQ_CLR_OFF, 32'hf);
        @(posedge clk);
        chk("irq clear", 0, 32'(irq));
        $display("shot done source %0d holdoff %0d", s, ho);
    endtask : shot
    initial begin
        int c0;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        foreach (OFS[i]) begin
            apb(0, OFS[i], 0);
            chk("reset value", 32'(RST[i]), rd);
        end
        apb(1, STATUS_OFF, 32'hf);
        apb(0, STATUS_OFF, 0);
        chk("status read only", 0, rd);
        apb(0, 8'h20, 0);
        chk("unmapped error", 1, 32'(er));
        apb(1, HOLDOFF_OFF, 0);
        apb(0, HOLDOFF_OFF, 0);
        chk("holdoff floor", 32'(SET_MIN), rd);
        $display("register test done");
        apb(1, IRQ_EN_OFF, 32'h1);
        shot(0, SRC_A, 0, 0, 1, 1);
        shot(0, SRC_B, 1, 1, 1, 1);
        shot(0, SRC_BOTH, 0, 1, 1, 1);
        shot(0, SRC_BOTH, 1, 0, 0, 1);
        shot(0, SRC_A, 0, 0, 1, 0);
        shot(300, SRC_A, 1, 0, 1, 1);
        for (int r = 0; r < 2; r++) begin
            apb(1, CTRL_OFF, ctl(r, 1, 0, 0, SRC_A, 0, 0));
            align(2000);
            c0 = n_a;
            repeat (2 * FR) @(posedge clk);
            chk("picture rate", 32'(2 / (r + 1)), 32'(n_a - c0));
            $display("self timed rate code %0d done", r);
        end
        // Slow gate last: its trip also blocks the following window
        shot(0, SRC_A, 0, 2, 1, 1);
        give_verdict();
    end
endmodule : strobe_timer_test
